// file: hdlc_framer_pkg.sv
// constants and types shared by the hdlc byte framer
//
// Contract
// - flag symbol is the byte 7e, marking frame start and end
// - more than six consecutive ones is an abort, distinct from flags and data
// - with nothing to send the transmitter fills the line with flags
// - transmitter inserts a zero after every five consecutive ones in content
// - receiver deletes the zero following five consecutive ones
// - frame is opening flag, data bytes, two checksum bytes, closing flag
// - 16-bit crc covers frame content without the inserted zeros
// - a closing flag may open the next frame; receiver accepts shared flags
// - framer off after reset; on only with parallel mode selected
// - host writes one byte per ready flag; device sends bytes in order
// - ready flag raises interrupt when transmit interrupt enable is set
// - no further byte: close frame, set frame-closed, send crc and flag
// - frame-closed set no sooner than 8 bit-times after ready was set
// - frame-closed cleared when closing flag starts; done 8 bit-times later
// - received byte sets rx flag and, if enabled, interrupt at once
// - host reads receive status before byte port; status may change after
// - ordinary data bytes carry error 0 and end-of-frame 0
// - good frame: end-of-frame 1, error 0 on last byte, two before are crc
// - error byte reads ff on abort and 7e on bad checksum
package hdlc_framer_pkg;
   localparam logic [7:0] FLAG_BYTE = 8'h7e;
   localparam logic [7:0] ABORT_BYTE = 8'hff;
   localparam logic [2:0] STUFF_ONES = 3'h5;
   localparam logic [2:0] FLAG_ONES = 3'h6;
   localparam logic [2:0] ONES_MAX = 3'h7;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [15:0] CRC_PRESET = 16'hffff;
   localparam logic [15:0] CRC_POLY_REV = 16'h8408;
   localparam logic [15:0] CRC_GOOD_RESIDUE = 16'hf0b8;
   localparam logic [3:0] CLOSED_MIN_BITS = 4'h8;

   typedef enum logic [1:0] {TX_FLAG, TX_DATA, TX_CRC} tx_state_t;

   typedef struct packed {
      logic err;
      logic eof;
   } rx_status_t;
endpackage

// file: hdlc_byte_framer.sv
// hdlc byte framer: host byte port in, serial hdlc line out and back
`timescale 1ns/100ps
`default_nettype none
module hdlc_byte_framer
   import hdlc_framer_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   // mode control
   input wire logic parallel_mode_select_in,
   input wire logic framer_enable_in,
   input wire logic tx_irq_enable_in,
   input wire logic rx_irq_enable_in,
   // host byte port
   input wire logic byte_wr_in,
   input wire logic [7:0] byte_wr_data_in,
   input wire logic byte_rd_in,
   output logic [7:0] byte_port_out,
   output rx_status_t rx_status_out,
   output logic tx_ready_flag_out,
   output logic frame_closed_flag_out,
   output logic rx_byte_flag_out,
   output logic irq_out,
   // serial line
   input wire logic bit_tick_in,
   input wire logic rx_bit_in,
   output logic tx_bit_out
);
   logic en;
   logic tick;
   assign en = parallel_mode_select_in & framer_enable_in;
   assign tick = clk_en_in & en & bit_tick_in;

   function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
      logic [15:0] r;
      r = {1'b0, c[15:1]};
      if (c[0] ^ b) begin
         r = r ^ CRC_POLY_REV;
      end
      return r;
   endfunction

   // ---------------- transmit ----------------
   tx_state_t tx_state_q;
   logic [7:0] hold_q;
   logic hold_full_q;
   logic hold_full_d;
   logic [7:0] tx_sh_q;
   logic [2:0] tx_cnt_q;
   logic [2:0] tx_ones_q;
   logic tx_stuff_q;
   logic [15:0] tx_crc_q;
   logic [15:0] tx_crc_nx;
   logic crc_hi_q;
   logic byte_end;
   logic load;
   logic tx_ready_d;

   assign byte_end = tick & ~tx_stuff_q & (tx_cnt_q == LAST_BIT);
   assign load = byte_end & hold_full_q & (tx_state_q != TX_CRC);
   assign tx_crc_nx = crc_bit(tx_crc_q, tx_sh_q[0]);

   always_comb begin
      hold_full_d = hold_full_q;
      if (clk_en_in) begin
         if (load) begin
            hold_full_d = 1'b0;
         end else if (byte_wr_in & ~hold_full_q) begin
            hold_full_d = 1'b1;
         end
         if (~en) begin
            hold_full_d = 1'b0;
         end
      end
      tx_ready_d = clk_en_in ? (en & ~hold_full_d) : tx_ready_flag_out;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hold_full_q <= 1'b0;
         hold_q <= 8'h00;
         tx_ready_flag_out <= 1'b0;
      end else begin
         hold_full_q <= hold_full_d;
         tx_ready_flag_out <= tx_ready_d;
         // writes while not ready are dropped so no byte is overwritten
         if (clk_en_in & byte_wr_in & ~hold_full_q) begin
            hold_q <= byte_wr_data_in;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in | (clk_en_in & ~en)) begin
         tx_state_q <= TX_FLAG;
         tx_sh_q <= FLAG_BYTE;
         tx_cnt_q <= 3'h0;
         tx_ones_q <= 3'h0;
         tx_stuff_q <= 1'b0;
         tx_crc_q <= CRC_PRESET;
         crc_hi_q <= 1'b0;
         frame_closed_flag_out <= 1'b0;
         tx_bit_out <= 1'b1;
      end else if (tick) begin
         if (tx_stuff_q) begin
            tx_bit_out <= 1'b0;
            tx_stuff_q <= 1'b0;
            tx_ones_q <= 3'h0;
         end else begin
            tx_bit_out <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_cnt_q <= tx_cnt_q + 3'h1;
            if (tx_state_q != TX_FLAG && tx_sh_q[0]) begin
               tx_ones_q <= tx_ones_q + 3'h1;
               tx_stuff_q <= (tx_ones_q == STUFF_ONES - 3'h1);
            end else begin
               tx_ones_q <= 3'h0;
            end
            if (tx_state_q == TX_DATA) begin
               tx_crc_q <= tx_crc_nx;
            end
            if (tx_cnt_q == LAST_BIT) begin
               unique case (tx_state_q)
                  TX_FLAG: begin
                     if (hold_full_q) begin
                        tx_state_q <= TX_DATA;
                        tx_sh_q <= hold_q;
                        tx_crc_q <= CRC_PRESET;
                     end else begin
                        tx_sh_q <= FLAG_BYTE;
                     end
                  end
                  TX_DATA: begin
                     if (hold_full_q) begin
                        tx_sh_q <= hold_q;
                     end else begin
                        tx_state_q <= TX_CRC;
                        tx_sh_q <= ~tx_crc_nx[7:0];
                        frame_closed_flag_out <= 1'b1;
                     end
                  end
                  TX_CRC: begin
                     if (!crc_hi_q) begin
                        tx_sh_q <= ~tx_crc_q[15:8];
                        crc_hi_q <= 1'b1;
                     end else begin
                        // closing flag may open the next frame right away
                        tx_state_q <= TX_FLAG;
                        tx_sh_q <= FLAG_BYTE;
                        crc_hi_q <= 1'b0;
                        frame_closed_flag_out <= 1'b0;
                     end
                  end
               endcase
            end
         end
      end
   end

   // ---------------- receive ----------------
   logic [7:0] rx_sh_q;
   logic [2:0] rx_cnt_q;
   logic [2:0] rx_ones_q;
   logic rx_in_frame_q;
   logic rx_has_bytes_q;
   logic [15:0] rx_crc_q;
   logic rx_acc;
   logic rx_flag_ev;
   logic rx_abort_ev;
   logic [7:0] rx_new;
   logic [15:0] rx_crc_byte;
   logic dlv;
   logic [7:0] dlv_data;
   rx_status_t dlv_st;
   logic rx_flag_d;

   always_comb begin
      rx_new = {rx_bit_in, rx_sh_q[7:1]};
      rx_crc_byte = rx_crc_q;
      for (int i = 0; i < 8; i++) begin
         rx_crc_byte = crc_bit(rx_crc_byte, rx_new[i]);
      end
      rx_abort_ev = tick & rx_bit_in & (rx_ones_q == FLAG_ONES);
      rx_flag_ev = tick & ~rx_bit_in & (rx_ones_q == FLAG_ONES);
      // a zero after five ones is stuffing and never enters the byte
      rx_acc = tick & (rx_bit_in ? (rx_ones_q < FLAG_ONES)
                                 : (rx_ones_q != STUFF_ONES && rx_ones_q != FLAG_ONES));
      dlv = 1'b0;
      dlv_data = rx_new;
      dlv_st = '{err: 1'b0, eof: 1'b0};
      if (rx_abort_ev & rx_in_frame_q & rx_has_bytes_q) begin
         dlv = 1'b1;
         dlv_data = ABORT_BYTE;
         dlv_st = '{err: 1'b1, eof: 1'b0};
      end else if (rx_flag_ev & rx_in_frame_q & rx_has_bytes_q) begin
         dlv = 1'b1;
         dlv_data = FLAG_BYTE;
         dlv_st.eof = 1'b1;
         dlv_st.err = (rx_crc_q != CRC_GOOD_RESIDUE) | (rx_cnt_q != LAST_BIT);
      end else if (rx_acc & rx_in_frame_q & (rx_cnt_q == LAST_BIT)) begin
         dlv = 1'b1;
      end
      rx_flag_d = rx_byte_flag_out;
      if (clk_en_in) begin
         if (byte_rd_in) begin
            rx_flag_d = 1'b0;
         end
         if (dlv) begin
            rx_flag_d = 1'b1;
         end
         if (~en) begin
            rx_flag_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in | (clk_en_in & ~en)) begin
         rx_sh_q <= 8'h00;
         rx_cnt_q <= 3'h0;
         rx_ones_q <= 3'h0;
         rx_in_frame_q <= 1'b0;
         rx_has_bytes_q <= 1'b0;
         rx_crc_q <= CRC_PRESET;
      end else if (tick) begin
         rx_ones_q <= rx_bit_in ? ((rx_ones_q == ONES_MAX) ? ONES_MAX : rx_ones_q + 3'h1)
                                : 3'h0;
         if (rx_abort_ev) begin
            rx_in_frame_q <= 1'b0;
         end else if (rx_flag_ev) begin
            rx_in_frame_q <= 1'b1;
            rx_has_bytes_q <= 1'b0;
            rx_cnt_q <= 3'h0;
            rx_crc_q <= CRC_PRESET;
         end else if (rx_acc) begin
            rx_sh_q <= rx_new;
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == LAST_BIT) begin
               rx_crc_q <= rx_crc_byte;
               rx_has_bytes_q <= 1'b1;
            end
         end
      end
   end

   // status changes only with a new byte, so reading it first is safe
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         byte_port_out <= 8'h00;
         rx_status_out <= '{err: 1'b0, eof: 1'b0};
         rx_byte_flag_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         rx_byte_flag_out <= rx_flag_d;
         if (clk_en_in) begin
            irq_out <= (tx_ready_d & tx_irq_enable_in) | (rx_flag_d & rx_irq_enable_in);
         end
         if (clk_en_in & dlv) begin
            byte_port_out <= dlv_data;
            rx_status_out <= dlv_st;
         end
      end
   end

   // ---------------- checks ----------------
   logic [3:0] bits_since_ready_q;
   always_ff @(posedge clk_in) begin
      if (rst_in | load) begin
         bits_since_ready_q <= 4'h0;
      end else if (tick && bits_since_ready_q != 4'hf) begin
         bits_since_ready_q <= bits_since_ready_q + 4'h1;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   AST_STUFF_ZERO: assert property (tick && tx_stuff_q |=> !tx_bit_out)
      else $error("inserted zero not sent");
   AST_ONES_LIMIT: assert property (tx_ones_q <= STUFF_ONES)
      else $error("more than five ones in content");
   AST_CLOSED_SET: assert property ($rose(frame_closed_flag_out) |-> tx_state_q == TX_CRC)
      else $error("frame closed without crc phase");
   AST_CLOSED_GAP: assert property ($rose(frame_closed_flag_out)
      |-> $past(bits_since_ready_q) >= CLOSED_MIN_BITS - 4'h1)
      else $error("frame closed too soon after ready");
   AST_CLOSED_CLR: assert property ($fell(frame_closed_flag_out) && en
      |-> tx_state_q == TX_FLAG && tx_sh_q == FLAG_BYTE)
      else $error("frame closed cleared outside closing flag");
   AST_IDLE_FLAGS: assert property (byte_end && tx_state_q == TX_FLAG && !hold_full_q
      |=> tx_sh_q == FLAG_BYTE)
      else $error("idle line not filled with flags");
   AST_RX_IRQ: assert property ($rose(rx_byte_flag_out) && $past(rx_irq_enable_in)
      |-> irq_out)
      else $error("rx interrupt missing");
   AST_TX_IRQ: assert property ($rose(tx_ready_flag_out) && $past(tx_irq_enable_in)
      |-> irq_out)
      else $error("tx interrupt missing");
   AST_ERR_BYTE: assert property (rx_status_out.err
      |-> byte_port_out == (rx_status_out.eof ? FLAG_BYTE : ABORT_BYTE))
      else $error("error byte value wrong");
   AST_DISABLED: assert property (clk_en_in && !en
      |=> tx_bit_out && !tx_ready_flag_out && !frame_closed_flag_out)
      else $error("framer active while disabled");

   COV_FRAME_CLOSE: cover property ($fell(frame_closed_flag_out));
   COV_GOOD_EOF: cover property (rx_status_out.eof && !rx_status_out.err);
   COV_ABORT: cover property (rx_status_out.err && !rx_status_out.eof);
   COV_STUFF: cover property (tick && tx_stuff_q);
endmodule
`default_nettype wire

// file: hdlc_line_model.sv
// serial line model: loops the transmit line back, with bit errors and marks on command
`timescale 1ns/100ps
`default_nettype none
module hdlc_line_model (
   // clock, reset
   input wire logic clk_in,
   input wire logic rst_in,
   // fault controls
   input wire logic flip_in,
   input wire logic mark_in,
   // line
   input wire logic tx_bit_in,
   output logic rx_bit_out
);
   // a held mark longer than six bits is what a broken frame looks like
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_bit_out <= 1'b1;
      end else begin
         rx_bit_out <= mark_in | (tx_bit_in ^ flip_in);
      end
   end
endmodule
`default_nettype wire

// file: hdlc_byte_framer_tb_top.sv
// self-checking bench for the hdlc byte framer over a looped-back line
`timescale 1ns/100ps
`default_nettype none
module hdlc_byte_framer_tb_top;
   import hdlc_framer_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, mode_sel = 1'b0, fr_en = 1'b0, tx_ie = 1'b0;
   logic rx_ie = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0, flip = 1'b0, mark = 1'b0;
   logic rx_bit, tx_bit, tx_rdy, closed, rx_flag, irq;
   logic prev_rdy = 1'b0, prev_closed = 1'b0, prev_tie = 1'b0, prev_rie = 1'b0;
   logic stale_rd = 1'b0;
   logic [7:0] wr_data = 8'h00, port;
   logic [15:0] line_q = 16'h0000;
   logic [9:0] rxq[$], expq[$];
   rx_status_t status;
   integer seed = 32'h5818, failures = 0, samples_checked = 0, cycles = 0;
   integer div = 0, since_rdy = 0, ones = 0, fall_t = -1;

   hdlc_byte_framer u_hdlc_byte_framer (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
      .parallel_mode_select_in(mode_sel), .framer_enable_in(fr_en), .tx_irq_enable_in(tx_ie),
      .rx_irq_enable_in(rx_ie), .byte_wr_in(wr), .byte_wr_data_in(wr_data), .byte_rd_in(rd),
      .byte_port_out(port), .rx_status_out(status), .tx_ready_flag_out(tx_rdy),
      .frame_closed_flag_out(closed), .rx_byte_flag_out(rx_flag), .irq_out(irq),
      .bit_tick_in(tick), .rx_bit_in(rx_bit), .tx_bit_out(tx_bit));
   hdlc_line_model u_hdlc_line_model (.clk_in(clk_in), .rst_in(rst_in), .flip_in(flip),
      .mark_in(mark), .tx_bit_in(tx_bit), .rx_bit_out(rx_bit));

   always #12.5 clk_in = ~clk_in;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [15:0] fcs(input logic [7:0] b[$]);
      logic [15:0] c;
      c = CRC_PRESET;
      foreach (b[i]) begin
         for (int k = 0; k < 8; k++) begin
            c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? CRC_POLY_REV : 16'h0000);
         end
      end
      return ~c;
   endfunction

   // flag is a palindrome, so bit order inside the window does not matter
   function automatic logic has_flag(input logic [15:0] v);
      has_flag = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (v[i +: 8] == FLAG_BYTE) begin
            has_flag = 1'b1;
         end
      end
   endfunction

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      div <= (div + 1) % 4;
      tick <= (div == 3);
      if (cycles == 20000) begin
         failures = failures + 1;
         end_sim();
      end
   end

   // host reader: status and data are taken together before the read pulse
   always @(posedge clk_in) begin
      if (rx_flag && !rd) begin
         rxq.push_back({status, port});
         rd <= 1'b1;
      end else begin
         rd <= stale_rd;
      end
   end

   always @(negedge clk_in) begin
      if (tick) begin
         line_q <= {tx_bit, line_q[15:1]};
         // a disabled framer holds the line at ones, which is no content
         ones <= (tx_bit && mode_sel && fr_en) ? ones + 1 : 0;
         since_rdy <= since_rdy + 1;
         if (tx_bit && ones >= 6 && mode_sel && fr_en) check(16'(ones + 1), 16'h0006);
      end
      if (tx_rdy && !prev_rdy) since_rdy <= 0;
      if (closed && !prev_closed) check(16'(since_rdy >= 8), 16'h0001);
      if (!closed && prev_closed) begin
         fall_t <= 0;
      end else if (tick && fall_t >= 0) begin
         fall_t <= fall_t + 1;
      end
      if (fall_t == 10) begin
         check(16'(has_flag(line_q)), 16'h0001);
         fall_t <= -1;
      end
      if (tx_ie == prev_tie && rx_ie == prev_rie) begin
         check(16'(irq), 16'((tx_rdy & tx_ie) | (rx_flag & rx_ie)));
      end
      prev_rdy <= tx_rdy;
      prev_closed <= closed;
      prev_tie <= tx_ie;
      prev_rie <= rx_ie;
   end

   // fault: 0 random data, 1 bit error, 2 abort, 3 all-ones data
   task automatic frame(input int n, input logic [1:0] fault);
      logic [7:0] b[$];
      logic [15:0] f;
      tx_ie <= 1'($random(seed));
      rx_ie <= 1'($random(seed));
      for (int i = 0; i < n; i++) begin
         b.push_back(fault == 2'd3 ? 8'hff : (fault != 2'd0 ? 8'h00 : 8'($random(seed))));
         @(posedge clk_in);
         while (!tx_rdy) @(posedge clk_in);
         wr <= 1'b1;
         wr_data <= b[i];
         @(posedge clk_in);
         wr <= 1'b0;
         if (i == 3 && fault == 2'd1) flip <= 1'b1;
         if (i == 3 && fault == 2'd2) mark <= 1'b1;
         repeat ((i == 3 && fault == 2'd2) ? 40 : 4) @(posedge clk_in);
         flip <= 1'b0;
         mark <= 1'b0;
      end
      while (!closed) @(posedge clk_in);
      while (closed) @(posedge clk_in);
      if (fault[0] == fault[1]) begin
         f = fcs(b);
         b.push_back(f[7:0]);
         b.push_back(f[15:8]);
         foreach (b[i]) expq.push_back({2'b00, b[i]});
         expq.push_back({2'b01, FLAG_BYTE});
      end
   endtask

   task automatic verify(input string name, input logic [9:0] last);
      repeat (200) @(posedge clk_in);
      if (expq.size() > 0) begin
         check(16'(rxq.size()), 16'(expq.size()));
         foreach (expq[i]) check(16'(rxq[i]), 16'(expq[i]));
      end else begin
         check(16'(rxq[$]), 16'(last));
      end
      rxq = {};
      expq = {};
      $display("test %s done", name);
   endtask

   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      check(16'({tx_rdy, closed, rx_flag, irq, tx_bit}), 16'h0001);
      for (int m = 1; m < 3; m++) begin
         mode_sel <= m[0];
         fr_en <= m[1];
         repeat (20) @(posedge clk_in);
         wr <= 1'b1;
         @(posedge clk_in);
         wr <= 1'b0;
         repeat (20) @(posedge clk_in);
         check(16'({tx_rdy, tx_bit, rxq.size() == 0}), 16'h0003);
      end
      $display("test disabled done");
      // one throwaway read pulse, sampled in the first data-mode cycle, clears only the rx byte flag, not the byte port
      stale_rd <= 1'b1;
      @(posedge clk_in);
      stale_rd <= 1'b0;
      mode_sel <= 1'b1;
      fr_en <= 1'b1;
      repeat (100) @(posedge clk_in);
      check(16'({tx_rdy, has_flag(line_q), rxq.size() == 0}), 16'h0007);
      $display("test idle done");
      frame(1, 2'd0);
      frame(3, 2'd3);
      for (int k = 0; k < 5; k++) frame(2 + ({$random(seed)} % 7), 2'd0);
      verify("frames", 10'h000);
      frame(4, 2'd1);
      verify("bad checksum", {2'b11, FLAG_BYTE});
      frame(6, 2'd2);
      verify("abort", {2'b10, ABORT_BYTE});
      end_sim();
   end
endmodule
`default_nettype wire
